//--- tws_top.sv
// Three-wire serial port, slave to an external serial clock.
// Assumes an AXI4-Lite master on the system clock; the serial clock,
// serial input and slave select come from outside and are synchronised.
`timescale 1ns/10ps
module tws_top
   import tws_pkg::*;
#(
   parameter int unsigned ADDR_W = 5
) (
   input wire logic clk_sys_i,              // System clock, 100 MHz
   input wire logic rst_b_i,                // Async reset, active low
   input wire logic ce_i,                   // Clock enable, freezes state
   // AXI4-Lite slave
   input wire logic [ADDR_W-1:0] awaddr,    // Write address
   input wire logic awvalid,                // Write address valid
   output logic awready,                    // Write address ready
   input wire logic [31:0] wdata,           // Write data
   input wire logic [3:0] wstrb,            // Write strobes
   input wire logic wvalid,                 // Write data valid
   output logic wready,                     // Write data ready
   output logic [1:0] bresp,                // Write response
   output logic bvalid,                     // Write response valid
   input wire logic bready,                 // Write response ready
   input wire logic [ADDR_W-1:0] araddr,    // Read address
   input wire logic arvalid,                // Read address valid
   output logic arready,                    // Read address ready
   output logic [31:0] rdata,               // Read data
   output logic [1:0] rresp,                // Read response
   output logic rvalid,                     // Read data valid
   input wire logic rready,                 // Read data ready
   // Serial link
   input wire logic serial_clock_line_i,    // Serial clock from far end
   input wire logic serial_in_line_i,       // Serial data in
   input wire logic slave_select_b_i,       // Slave select, active low
   output logic serial_out_line_o,          // Serial out pin level
   output logic serial_out_line_oe_b_o      // Pin output enable, low drives
);
   typedef struct packed {
      logic aw_got;
      logic [ADDR_W-1:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic w_lane0;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic en;
      logic trmd;
      logic sse;
      logic dir;
      logic dap;
      logic [CLK_SEL_W-1:0] clksel;
      logic [7:0] txbuf;
      logic pdir;
      logic platch;
      logic start_pend;
      logic busy;
      logic [2:0] cnt;
      logic can_shift;
      logic [7:0] tx_sh;
      logic [7:0] rx_sh;
      logic so;
      logic pin;
      logic pin_oe_b;
      logic [1:0] sck_sy;
      logic sck_prev;
      logic [1:0] si_sy;
      logic [1:0] ss_sy;
   } tws_st_t;

   tws_st_t s_q, s_d;
   tws_buf_if #(.W(8)) bif ();
   logic do_wr, do_rd, sck_rise, sck_fall, sel_ok;
   logic smp_edge, sft_edge, last_bit, start_now;
   logic [7:0] rx_next;

   ////////////////////////////////////////////////////////////////////////
   // Receive buffer; a full buffer holds off new transfers
   tws_buf #(.W(8), .DEPTH(2)) u_buf (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .bus(bif)
   );

   ////////////////////////////////////////////////////////////////////////
   // Edge detection on the synchronised serial clock
   assign sck_rise = s_q.sck_sy[1] && !s_q.sck_prev;
   assign sck_fall = !s_q.sck_sy[1] && s_q.sck_prev;
   // Slave select only gates the clock when its use is enabled
   assign sel_ok = !s_q.sse || !s_q.ss_sy[1];
   // Phase clear samples on rising, phase set samples on falling
   assign smp_edge = s_q.busy && sel_ok && (s_q.dap ? sck_fall : sck_rise);
   assign sft_edge = s_q.busy && sel_ok && s_q.can_shift &&
                     (s_q.dap ? sck_rise : sck_fall);
   assign last_bit = (s_q.cnt == 3'(FRAME_BITS - 1));
   assign rx_next = s_q.dir ? {s_q.si_sy[1], s_q.rx_sh[7:1]}
                            : {s_q.rx_sh[6:0], s_q.si_sy[1]};
   assign do_wr = s_q.aw_got && s_q.w_got && !s_q.bvalid;
   assign do_rd = arvalid && s_q.arready;
   // A pending start waits for an idle engine and buffer room
   assign start_now = s_q.start_pend && s_q.en && !s_q.busy &&
                      bif.wr_ready;

   // Buffer hookups: push the finished byte, pop on shift-register read
   assign bif.wr_valid = smp_edge && last_bit;
   assign bif.wr_data = rx_next;
   assign bif.rd_ready = do_rd && (araddr == OFS_SHIFT);
   assign bif.flush = do_wr && (s_q.aw_addr == OFS_MODE) && s_q.w_lane0 &&
                      !s_q.w_data[MODE_EN_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic: bus slave, register file, serial engine, pin
   always_comb begin
      s_d = s_q;
      // Input synchronisers; first stage feeds only the second
      s_d.sck_sy = {s_q.sck_sy[0], serial_clock_line_i};
      s_d.si_sy = {s_q.si_sy[0], serial_in_line_i};
      s_d.ss_sy = {s_q.ss_sy[0], slave_select_b_i};
      s_d.sck_prev = s_q.sck_sy[1];

      // Address and data are taken in either order
      if (awvalid && s_q.awready) begin
         s_d.aw_got = 1'b1;
         s_d.aw_addr = awaddr;
      end
      if (wvalid && s_q.wready) begin
         s_d.w_got = 1'b1;
         s_d.w_data = wdata;
         s_d.w_lane0 = wstrb[0];
      end
      if (s_q.bvalid && bready) begin
         s_d.bvalid = 1'b0;
      end

      // Serial engine
      if (smp_edge) begin
         s_d.rx_sh = rx_next;
         s_d.cnt = s_q.cnt + 3'h1;
         s_d.can_shift = 1'b1;
         if (last_bit) begin
            s_d.busy = 1'b0;
            s_d.can_shift = 1'b0;
         end
      end
      if (sft_edge) begin
         s_d.tx_sh = s_q.dir ? {1'b0, s_q.tx_sh[7:1]}
                             : {s_q.tx_sh[6:0], 1'b0};
         s_d.can_shift = 1'b0;
      end
      if (start_now) begin
         s_d.start_pend = 1'b0;
         s_d.busy = 1'b1;
         s_d.cnt = 3'h0;
         s_d.can_shift = 1'b0;
         s_d.rx_sh = 8'h00;
         s_d.tx_sh = s_q.trmd ? s_q.txbuf : 8'h00;
      end

      // Register writes, low byte lane only
      if (do_wr) begin
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = RESP_OKAY;
         unique case (s_q.aw_addr)
            OFS_MODE: begin
               if (s_q.w_lane0) begin
                  s_d.en = s_q.w_data[MODE_EN_BIT];
                  s_d.trmd = s_q.w_data[MODE_TRMD_BIT];
                  s_d.sse = s_q.w_data[MODE_SSE_BIT];
                  s_d.dir = s_q.w_data[MODE_DIR_BIT];
                  if (!s_q.w_data[MODE_EN_BIT]) begin
                     s_d.busy = 1'b0;
                     s_d.start_pend = 1'b0;
                     s_d.rx_sh = 8'h00;
                     s_d.tx_sh = 8'h00;
                     s_d.cnt = 3'h0;
                     s_d.can_shift = 1'b0;
                  end
               end
            end
            OFS_CLKSEL: begin
               if (s_q.w_lane0) begin
                  s_d.dap = s_q.w_data[CLK_DAP_BIT];
                  s_d.clksel = s_q.w_data[CLK_SEL_LSB +: CLK_SEL_W];
               end
            end
            OFS_TXBUF: begin
               if (s_q.w_lane0) begin
                  s_d.txbuf = s_q.w_data[7:0];
                  // Transmit start only in transmit mode while enabled
                  if (s_q.en && s_q.trmd) begin
                     s_d.start_pend = 1'b1;
                  end
               end
            end
            OFS_PORT: begin
               if (s_q.w_lane0) begin
                  s_d.pdir = s_q.w_data[PORT_DIR_BIT];
                  s_d.platch = s_q.w_data[PORT_LATCH_BIT];
               end
            end
            OFS_SHIFT: begin
               s_d.bresp = RESP_SLVERR;   // Read-only location
            end
            default: begin
               s_d.bresp = RESP_SLVERR;
            end
         endcase
      end

      // Register reads; one read in flight, answered a cycle later
      if (s_q.rvalid && rready) begin
         s_d.rvalid = 1'b0;
      end
      if (do_rd) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = RESP_OKAY;
         s_d.rdata = 32'h0000_0000;
         unique case (araddr)
            OFS_MODE: begin
               s_d.rdata[MODE_EN_BIT] = s_q.en;
               s_d.rdata[MODE_TRMD_BIT] = s_q.trmd;
               s_d.rdata[MODE_SSE_BIT] = s_q.sse;
               s_d.rdata[MODE_DIR_BIT] = s_q.dir;
               s_d.rdata[MODE_BUSY_BIT] = s_q.busy;
            end
            OFS_CLKSEL: begin
               s_d.rdata[CLK_DAP_BIT] = s_q.dap;
               s_d.rdata[CLK_SEL_LSB +: CLK_SEL_W] = s_q.clksel;
            end
            OFS_TXBUF: begin
               s_d.rdata[7:0] = s_q.txbuf;
            end
            OFS_SHIFT: begin
               s_d.rdata[7:0] = bif.rd_valid ? bif.rd_data : 8'h00;
               // Receive-only mode restarts on every read
               if (s_q.en && !s_q.trmd) begin
                  s_d.start_pend = 1'b1;
               end
            end
            OFS_PORT: begin
               s_d.rdata[PORT_DIR_BIT] = s_q.pdir;
               s_d.rdata[PORT_LATCH_BIT] = s_q.platch;
            end
            default: begin
               s_d.rresp = RESP_SLVERR;
            end
         endcase
      end

      // Handshake readies as registers so the outputs come from flops
      s_d.awready = !s_d.aw_got && !s_d.bvalid;
      s_d.wready = !s_d.w_got && !s_d.bvalid;
      s_d.arready = !s_d.rvalid;

      // Serial output from the new settings, so any write shows at once
      if (!s_d.en) begin
         if (s_d.trmd && s_d.dap) begin
            s_d.so = s_d.dir ? s_d.txbuf[0]
                             : s_d.txbuf[7];
         end else begin
            s_d.so = 1'b0;
         end
      end else if (s_d.trmd) begin
         // Holds the last bit sent once the frame is over
         s_d.so = s_d.dir ? s_d.tx_sh[0] : s_d.tx_sh[7];
      end else begin
         s_d.so = 1'b0;
      end
      // Pin: direction bit clear drives, latch ORs onto the line
      s_d.pin = s_d.so | s_d.platch;
      s_d.pin_oe_b = s_d.pdir;
   end

   ////////////////////////////////////////////////////////////////////////
   // State register; reset leaves the port off and the line low
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_q <= '0;
         s_q.en <= MODE_RST[MODE_EN_BIT];
         s_q.trmd <= MODE_RST[MODE_TRMD_BIT];
         s_q.sse <= MODE_RST[MODE_SSE_BIT];
         s_q.dir <= MODE_RST[MODE_DIR_BIT];
         s_q.dap <= CLKSEL_RST[CLK_DAP_BIT];
         s_q.clksel <= CLKSEL_RST[CLK_SEL_LSB +: CLK_SEL_W];
         s_q.txbuf <= TXBUF_RST;
         s_q.pdir <= PORT_DIR_RST;
         s_q.platch <= PORT_LATCH_RST;
         s_q.pin_oe_b <= PORT_DIR_RST;
         s_q.sck_sy <= 2'h3;
         s_q.sck_prev <= 1'b1;
         s_q.ss_sy <= 2'h3;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs straight from flops
   assign awready = s_q.awready;
   assign wready = s_q.wready;
   assign bvalid = s_q.bvalid;
   assign bresp = s_q.bresp;
   assign arready = s_q.arready;
   assign rvalid = s_q.rvalid;
   assign rdata = s_q.rdata;
   assign rresp = s_q.rresp;
   assign serial_out_line_o = s_q.pin;
   assign serial_out_line_oe_b_o = s_q.pin_oe_b;
endmodule : tws_top

//--- tws_pkg.sv
// Constants, register map and field layout of the three-wire serial port.
// Assumes a 32-bit AXI4-Lite register bus and an 8-bit serial frame.
//
// What this block does
// - Data moves over three lines only: serial clock, serial out, serial in.
// - Enabled for transmit: a transmit buffer write starts a full-duplex transfer.
// - Enabled for receive only: a shift register read starts reception.
// - Serial out is low unless transmit mode allows data; while off, data phase must be set too.
// - Off, transmit mode, data phase, msb-first: out shows buffer bit 7.
// - Off, transmit mode, data phase, lsb-first: out shows buffer bit 0.
// - After reset the port is disabled, transmit mode clear, output low.
// - After a transmission the output keeps the last bit sent.
// - Writes to enable, mode, phase or direction update the output.
// - Pin level follows port direction bit, port latch and serial output.
// - Clearing enable resets the busy flag and the shift register.
package tws_pkg;
   localparam int unsigned FRAME_BITS = 8;
   // Register byte offsets
   localparam logic [4:0] OFS_MODE = 5'h00;
   localparam logic [4:0] OFS_CLKSEL = 5'h04;
   localparam logic [4:0] OFS_TXBUF = 5'h08;
   localparam logic [4:0] OFS_SHIFT = 5'h0c;
   localparam logic [4:0] OFS_PORT = 5'h10;
   // Mode register fields
   localparam int unsigned MODE_EN_BIT = 7;
   localparam int unsigned MODE_TRMD_BIT = 6;
   localparam int unsigned MODE_SSE_BIT = 5;
   localparam int unsigned MODE_DIR_BIT = 4;
   localparam int unsigned MODE_BUSY_BIT = 0;
   // Clock select register fields
   localparam int unsigned CLK_DAP_BIT = 4;
   localparam int unsigned CLK_SEL_LSB = 0;
   localparam int unsigned CLK_SEL_W = 3;
   // Port register fields
   localparam int unsigned PORT_DIR_BIT = 0;
   localparam int unsigned PORT_LATCH_BIT = 1;
   // Reset values
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] CLKSEL_RST = 8'h00;
   localparam logic [7:0] TXBUF_RST = 8'h00;
   localparam logic PORT_DIR_RST = 1'b1;
   localparam logic PORT_LATCH_RST = 1'b0;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tws_pkg

//--- tws_buf_if.sv
// Carrier between the serial engine and its receive buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface tws_buf_if #(parameter int unsigned W = 8);
   logic wr_valid;
   logic wr_ready;
   logic [W-1:0] wr_data;
   logic rd_valid;
   logic rd_ready;
   logic [W-1:0] rd_data;
   logic flush;
   modport src (output wr_valid, output wr_data, input wr_ready,
                input rd_valid, input rd_data, output rd_ready,
                output flush);
   modport fifo (input wr_valid, input wr_data, output wr_ready,
                 output rd_valid, output rd_data, input rd_ready,
                 input flush);
endinterface : tws_buf_if

//--- tws_buf.sv
// Small receive buffer, valid/ready on both sides.
// Assumes one clock and a clock enable shared with the serial engine.
`timescale 1ns/10ps
module tws_buf #(
   parameter int unsigned W = 8,
   parameter int unsigned DEPTH = 2
) (
   input wire logic clk_sys_i,   // System clock
   input wire logic rst_b_i,     // Async reset, active low
   input wire logic ce_i,        // Clock enable
   tws_buf_if.fifo bus           // Fill and drain ports
);
   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [PW:0] cnt;
   } tws_buf_st_t;
   tws_buf_st_t s_q, s_d;
   logic push, pop;

   ////////////////////////////////////////////////////////////////////////
   // Honest full and empty straight from the count
   assign bus.wr_ready = (s_q.cnt != (PW+1)'(DEPTH));
   assign bus.rd_valid = (s_q.cnt != '0);
   assign bus.rd_data = s_q.mem[s_q.rp];
   assign push = bus.wr_valid && bus.wr_ready;
   assign pop = bus.rd_valid && bus.rd_ready;

   // Next state; flush wins over a push in the same cycle
   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wp] = bus.wr_data;
         s_d.wp = (s_q.wp == PW'(DEPTH-1)) ? '0 : s_q.wp + 1'b1;
      end
      if (pop) begin
         s_d.rp = (s_q.rp == PW'(DEPTH-1)) ? '0 : s_q.rp + 1'b1;
      end
      s_d.cnt = s_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
      if (bus.flush) begin
         s_d.wp = '0;
         s_d.rp = '0;
         s_d.cnt = '0;
      end
   end

   // State register
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_q <= '0;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end
endmodule : tws_buf

//--- tws_checker.sv
// Port assertions for the three-wire serial port top.
// Assumes one clock domain and an async active-low reset.
`timescale 1ns/10ps
module tws_checker (
   input wire logic clk_sys_i, // Clock
   input wire logic rst_b_i, // Reset, active low
   input wire logic awvalid, // Write address valid
   input wire logic awready, // Write address ready
   input wire logic wvalid, // Write data valid
   input wire logic wready, // Write data ready
   input wire logic [1:0] bresp, // Write response
   input wire logic bvalid, // Write response valid
   input wire logic bready, // Write response ready
   input wire logic arvalid, // Read address valid
   input wire logic arready, // Read address ready
   input wire logic [31:0] rdata, // Read data
   input wire logic rvalid, // Read data valid
   input wire logic rready, // Read data ready
   input wire logic serial_clock_line_i, // Link clock
   input wire logic serial_out_line_o, // Pin level
   input wire logic serial_out_line_oe_b_o // Pin enable, low drives
);
   logic [3:0] quiet_q;
   logic [3:0] quiet_d;
   logic sclk_q;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_b_i);
   ////////////////////////////////////////////////////////////////////////
   // Idle cycles since a bus access or link clock edge, saturating
   always_comb begin
      quiet_d = (quiet_q == 4'hf) ? quiet_q : quiet_q + 4'h1;
      if ((awvalid && awready) || (arvalid && arready) ||
          (serial_clock_line_i != sclk_q)) begin
         quiet_d = 4'h0;
      end
   end
   // Counter and link clock history
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         quiet_q <= 4'h0;
         sclk_q <= 1'b1;
      end else begin
         quiet_q <= quiet_d;
         sclk_q <= serial_clock_line_i;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   property p_rst_out;
      $rose(rst_b_i) |-> !serial_out_line_o && serial_out_line_oe_b_o;
   endproperty
   property p_bhold;
      bvalid && !bready |=> bvalid && $stable(bresp);
   endproperty
   property p_rhold;
      rvalid && !rready |=> rvalid && $stable(rdata);
   endproperty
   property p_bblk;
      bvalid |-> !awready && !wready;
   endproperty
   property p_rblk;
      rvalid |-> !arready;
   endproperty
   property p_rlat;
      arvalid && arready |=> rvalid;
   endproperty
   property p_wlat;
      awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid;
   endproperty
   property p_quiet;
      quiet_q == 4'hf |-> $stable(serial_out_line_o);
   endproperty
   a_rst_out: assert property (p_rst_out)
      else $error("Pin not idle after reset");
   a_bhold: assert property (p_bhold)
      else $error("Write response dropped early");
   a_rhold: assert property (p_rhold)
      else $error("Read data dropped early");
   a_bblk: assert property (p_bblk)
      else $error("Write taken while response pending");
   a_rblk: assert property (p_rblk)
      else $error("Read taken while data pending");
   a_rlat: assert property (p_rlat)
      else $error("Read answer late");
   a_wlat: assert property (p_wlat)
      else $error("Write answer at wrong cycle");
   a_quiet: assert property (p_quiet)
      else $error("Serial out moved while idle");
   c_wr: cover property (awvalid && awready && wvalid && wready);
   c_rd: cover property (rvalid && rready);
   c_hold: cover property (quiet_q == 4'hf && serial_out_line_o);
endmodule : tws_checker

bind tws_top tws_checker u_chk (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
   .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
   .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
   .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
   .serial_clock_line_i(serial_clock_line_i),
   .serial_out_line_o(serial_out_line_o),
   .serial_out_line_oe_b_o(serial_out_line_oe_b_o));

//--- tws_peer.sv
// Far-end serial master: drives the link clock, select and data.
// Assumes the port samples on falling and shifts on rising clock.
`timescale 1ns/10ps
module tws_peer (
   output logic sclk_o, // Link clock, idle high
   output logic sdi_o, // Data towards the port
   output logic ss_b_o, // Select, active low
   input wire logic sdo_i // Pin level from the port
);
   // Idle levels; clock stands still between frames
   initial begin
      sclk_o = 1'b1;
      sdi_o = 1'b0;
      ss_b_o = 1'b1;
   end
   // One eight-bit frame, msb first, 80 ns clock period
   task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
      ss_b_o = 1'b0;
      sdi_o = tx[7];
      #43;
      for (int i = 7; i >= 0; i--) begin
         sclk_o = 1'b0;
         #39;
         rx[i] = sdo_i; // Late in the low phase, output long settled
         #1;
         sclk_o = 1'b1;
         sdi_o = (i > 0) ? tx[(i+7)%8] : ~sdi_o;
         #40;
      end
      ss_b_o = 1'b1; // Released data line already shows a flipped bit
   endtask : frame
endmodule : tws_peer

//--- tb.sv
// Self-checking bench for the three-wire serial port top.
// Assumes the far-end model and the bound port checker.
`timescale 1ns/10ps
module tb;
   import tws_pkg::*;
   logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [4:0] awaddr = 5'h00, araddr = 5'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, so, oe_b, sclk, sdi, ss_b;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int errors = 0, cmp_count = 0;
   wire pin = oe_b ? ~so : so; // Undriven pin shows no stale level
   tws_top u_tws_top (.clk_sys_i(clk), .rst_b_i(rst_b), .ce_i(ce),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .serial_clock_line_i(sclk), .serial_in_line_i(sdi),
      .slave_select_b_i(ss_b), .serial_out_line_o(so),
      .serial_out_line_oe_b_o(oe_b));
   tws_peer u_tws_peer (.sclk_o(sclk), .sdi_o(sdi), .ss_b_o(ss_b),
      .sdo_i(pin));
   ////////////////////////////////////////////////////////////////////////
   // 100 MHz system clock
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic results();
      $display("Comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // A used-up wait bound ends the run as a failure
   task automatic tmo(int n);
      if (n >= 50) begin
         errors++;
         results();
      end
   endtask : tmo
   task automatic wr(logic [4:0] a, logic [7:0] d, logic [1:0] er);
      int n;
      logic aw = 1'b1, w = 1'b1;
      @(posedge clk);
      {awaddr, wdata, wstrb} <= {a, 24'h0, d, 4'h1};
      {awvalid, wvalid} <= 2'b11;
      for (n = 0; n < 50 && (aw || w); n++) begin
         @(posedge clk);
         if (awready) aw = 1'b0;
         if (wready) w = 1'b0;
         {awvalid, wvalid} <= {aw, w};
      end
      for (n = 0; n < 50 && bvalid !== 1'b1; n++) @(posedge clk);
      tmo(n);
      bready <= 1'b1; // Late ready keeps the response standing a cycle
      @(posedge clk);
      chk("bresp", bresp, er);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(logic [4:0] a, output logic [31:0] d,
      input logic [1:0] er);
      int n;
      logic ar = 1'b1;
      @(posedge clk);
      {araddr, arvalid} <= {a, 1'b1};
      for (n = 0; n < 50 && ar; n++) begin
         @(posedge clk);
         if (arready) ar = 1'b0;
         arvalid <= ar;
      end
      for (n = 0; n < 50 && rvalid !== 1'b1; n++) @(posedge clk);
      tmo(n);
      rready <= 1'b1;
      @(posedge clk);
      d = rdata;
      chk("rresp", rresp, er);
      rready <= 1'b0;
   endtask : rd
   task automatic idle();
      int n;
      logic [31:0] v;
      for (n = 0; n < 50; n++) begin
         rd(OFS_MODE, v, RESP_OKAY);
         if (v[MODE_BUSY_BIT] === 1'b0) break;
      end
      tmo(n);
   endtask : idle
   // Clock select first, then mode bits, then enable
   task automatic setup(logic dir, logic tm);
      wr(OFS_CLKSEL, 8'h10, RESP_OKAY);
      wr(OFS_MODE, {1'b0, tm, 1'b0, dir, 4'h0}, RESP_OKAY);
      wr(OFS_MODE, {1'b1, tm, 1'b0, dir, 4'h0}, RESP_OKAY);
   endtask : setup
   task automatic rst_chk();
      logic [31:0] v;
      rst_b <= 1'b0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      chk("pin", {oe_b, so}, 2'b10);
      for (int i = 0; i < 5; i++) begin
         rd(5'(i * 4), v, RESP_OKAY);
         chk("reset value", v, (i == 4) ? 32'h1 : 32'h0);
      end
   endtask : rst_chk
   function automatic logic [7:0] rev(logic [7:0] x);
      for (int k = 0; k < 8; k++) rev[k] = x[7-k];
   endfunction : rev
   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] v;
      logic [7:0] tx, px, prx;
      logic [7:0] pb [3];
      logic dir;
      void'($urandom(4));
      rst_chk();
      rd(5'h14, v, RESP_SLVERR);
      chk("unmapped", v, 32'h0);
      wr(OFS_SHIFT, 8'h5a, RESP_SLVERR);
      wr(OFS_PORT, 8'h02, RESP_OKAY);
      repeat (3) @(posedge clk);
      chk("latch pin", {oe_b, so}, 2'b01);
      wr(OFS_PORT, 8'h00, RESP_OKAY);
      $display("Test reset and map done");
      // Static output for every setting except enabled transmit
      for (int i = 0; i < 12; i++) begin
         tx = 8'($urandom);
         wr(OFS_MODE, 8'h00, RESP_OKAY);
         wr(OFS_TXBUF, tx, RESP_OKAY);
         wr(OFS_CLKSEL, {3'h0, i[1], 4'h0}, RESP_OKAY);
         wr(OFS_MODE, {i[3], i[2], 1'b0, i[0], 4'h0}, RESP_OKAY);
         repeat (3) @(posedge clk);
         v[0] = !i[3] && i[2] && i[1] && (i[0] ? tx[0] : tx[7]);
         chk("static out", so, v[0]);
      end
      $display("Test output table done");
      for (int i = 0; i < 6; i++) begin
         dir = !i[0];
         tx = (i == 0) ? 8'h81 : 8'($urandom);
         px = 8'($urandom);
         setup(dir, 1'b1);
         wr(OFS_TXBUF, tx, RESP_OKAY);
         repeat (10) @(posedge clk);
         u_tws_peer.frame(px, prx);
         chk("peer rx", prx, dir ? rev(tx) : tx);
         idle();
         chk("last bit", so, dir ? tx[7] : tx[0]);
         rd(OFS_SHIFT, v, RESP_OKAY);
         chk("port rx", v, dir ? rev(px) : px);
      end
      $display("Test duplex done");
      // Fill the receive buffer; the third start waits for room
      for (int i = 0; i < 3; i++) begin
         pb[i] = 8'($urandom);
         wr(OFS_TXBUF, 8'($urandom), RESP_OKAY);
         repeat (10) @(posedge clk);
         if (i == 2) begin
            rd(OFS_MODE, v, RESP_OKAY);
            chk("held start", v[MODE_BUSY_BIT], 1'b0);
            rd(OFS_SHIFT, v, RESP_OKAY);
            chk("buffer", v, pb[0]);
            repeat (10) @(posedge clk);
         end
         u_tws_peer.frame(pb[i], prx);
         idle();
      end
      for (int i = 1; i < 4; i++) begin
         rd(OFS_SHIFT, v, RESP_OKAY);
         chk("drain", v, (i < 3) ? pb[i] : 8'h00);
      end
      $display("Test buffer done");
      // Receive only: each shift read starts the next reception
      setup(1'b0, 1'b0);
      rd(OFS_SHIFT, v, RESP_OKAY);
      for (int i = 0; i < 2; i++) begin
         pb[i] = 8'($urandom);
         repeat (10) @(posedge clk);
         u_tws_peer.frame(pb[i], prx);
         idle();
         chk("rx only out", {so, prx}, 9'h0);
         if (i == 0) rd(OFS_SHIFT, v, RESP_OKAY);
         if (i == 0) chk("rx only", v, pb[0]);
      end
      wr(OFS_MODE, 8'h00, RESP_OKAY);
      rd(OFS_SHIFT, v, RESP_OKAY);
      chk("flushed", v, 32'h0);
      $display("Test receive only done");
      rst_chk();
      $display("Test second reset done");
      results();
   end
endmodule : tb
